// [design/iscdr_pkg.sv]
// constants for the two-wire bus status, clock and data register block
package iscdr_pkg;
	// register byte addresses on the avalon slave
	localparam logic [4:0] OFS_CONTROL     = 5'h00;
	localparam logic [4:0] OFS_STATUS_ONE  = 5'h04;
	localparam logic [4:0] OFS_STATUS_TWO  = 5'h08;
	localparam logic [4:0] OFS_SPEED_CFG   = 5'h0C;
	localparam logic [4:0] OFS_BYTE_BUFFER = 5'h10;
	// control register fields
	localparam int CTL_INTERFACE_ON   = 0;
	localparam int CTL_IRQ_ALLOW      = 1;
	localparam int CTL_BROADCAST_ALOW = 2;
	localparam int CTL_START_REQUEST  = 3;
	// status one fields
	localparam int S1_START_SENT  = 0;
	localparam int S1_ROLE        = 1;
	localparam int S1_BYTE_DONE   = 3;
	localparam int S1_COMMON_EVT  = 7;
	// status two fields, bits 7:5 always zero
	localparam int S2_BROADCAST_HIT  = 0;
	localparam int S2_FRAMING_FAULT  = 1;
	localparam int S2_CONTENTION     = 2;
	localparam int S2_STOP_SEEN      = 3;
	localparam int S2_MISSING_HSHAKE = 4;
	// speed configuration fields
	localparam int SPD_FAST_SELECT = 7;
	localparam int SPD_DIV_MSB     = 6;
	// reset values
	localparam logic [7:0] RST_CONTROL     = 8'h00;
	localparam logic [7:0] RST_SPEED_CFG   = 8'h00;
	localparam logic [7:0] RST_BYTE_BUFFER = 8'h00;
	localparam logic [7:0] RST_STATUS_TWO  = 8'h00;
	localparam logic [31:0] RD_UNMAPPED    = 32'h0000_0000;
endpackage

// [design/iscdr_core.sv]
// status, clock configuration and data register logic of a two-wire bus port
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps

// Notes on behaviour
// [R1] start request sets controller role; disabling the interface clears it
// [R2] stop seen or arbitration lost returns the interface to slave role
// [R3] start-sent flag sets once start is generated; interrupts when allowed
// [R4] start-sent clears after status one read then byte buffer write
// [R5] status two bits 7 to 5 always read zero
// [R6] missing-handshake flag sets on nack; cleared by status two read
// [R7] missing-handshake flag never stretches SCL; start/byte flags may
// [R8] after nack with zero bits software must release both lines
// [R9] slave stop after acknowledge sets stop-seen; read clears, no stretch
// [R10] lost arbitration sets contention-lost; read clears, no stretch
// [R11] no arbitration during acknowledge bit as master receiver
// [R12] misplaced start or stop sets framing-fault; read clears, no stretch
// [R13] after bus error the master should issue stop or repeated start
// [R14] general call in slave with broadcast allowed sets hit; stop clears
// [R15] speed config bit 7 selects fast speed, kept when disabled
// [R16] seven-bit divider sets SCL rate, kept when disabled
// [R17] byte buffer write in transmitter mode starts transmission
// [R18] first rx byte captured automatically; later ones after buffer read
// [R19] framing fault or nack also raise the common event flag
// [R20] status two read before byte end lets missing-handshake set again
// [R21] one interrupt output: or of event flags gated by irq allow
module iscdr_core (
	input  wire logic        i_clk,            // peripheral clock
	input  wire logic        i_resetn,         // synchronous reset, low
	input  wire logic [4:0]  i_address,        // avalon byte address
	input  wire logic        i_read,           // avalon read
	input  wire logic        i_write,          // avalon write
	input  wire logic [3:0]  i_byteenable,     // avalon byte enables
	input  wire logic [31:0] i_writedata,      // avalon write data
	output logic      [31:0] o_readdata,       // avalon read data
	output logic             o_waitrequest,    // avalon wait
	input  wire logic        i_start_done,     // engine made start, pulse
	input  wire logic        i_stop_detected,  // stop on bus, pulse
	input  wire logic        i_stop_after_ack, // stop followed ack, pulse
	input  wire logic        i_arb_lost,       // arbitration lost, pulse
	input  wire logic        i_rx_ack_slot,    // master rx ack bit, level
	input  wire logic        i_nack,           // no ack seen, level
	input  wire logic        i_misplaced,      // misplaced start/stop
	input  wire logic        i_gcall_addr,     // general call address
	input  wire logic        i_byte_done,      // byte finished, pulse
	input  wire logic        i_tx_mode,        // transmitter mode level
	input  wire logic        i_addr_done,      // address phase ended
	input  wire logic        i_rx_valid,       // received byte valid
	input  wire logic [7:0]  i_rx_byte,        // received byte
	output logic             o_rx_ready,       // may accept a byte
	output logic             o_start_req,      // start pending
	output logic             o_tx_load,        // transmit byte, pulse
	output logic      [7:0]  o_tx_byte,        // byte to transmit
	output logic             o_scl_hold,       // stretch SCL low
	output logic             o_role_master,    // controller role
	output logic             o_fast_speed,     // fast speed select
	output logic      [6:0]  o_scl_divider,    // SCL divider
	output logic             o_irq             // interrupt request
);

	// registered state
	logic [7:0] control_q;
	logic [7:0] speed_q;
	logic [7:0] buffer_q;
	logic       role_q;
	logic       start_pend_q;
	logic       start_sent_q;
	logic       byte_done_q;
	logic       s1_read_q;
	logic       af_q;
	logic       stop_seen_flag_q;
	logic       contention_lost_flag_q;
	logic       framing_fault_flag_q;
	logic       broadcast_hit_flag_q;
	logic       rx_ready_q;
	logic       ack_q;
	logic       tx_load_q;
	logic [31:0] rdata_q;

	// bus decode: every access takes one wait cycle so read data can register
	wire req        = i_read | i_write;
	wire done       = req & ack_q;
	wire lane0      = i_byteenable[0];
	wire sel_ctl    = (i_address == iscdr_pkg::OFS_CONTROL);
	wire sel_s1     = (i_address == iscdr_pkg::OFS_STATUS_ONE);
	wire sel_s2     = (i_address == iscdr_pkg::OFS_STATUS_TWO);
	wire sel_spd    = (i_address == iscdr_pkg::OFS_SPEED_CFG);
	wire sel_buf    = (i_address == iscdr_pkg::OFS_BYTE_BUFFER);
	wire wr_ctl     = done & i_write & lane0 & sel_ctl;
	wire wr_spd     = done & i_write & lane0 & sel_spd;
	wire wr_buf     = done & i_write & lane0 & sel_buf;
	wire rd_s1      = done & i_read & sel_s1;
	wire rd_s2      = done & i_read & sel_s2;
	wire rd_buf     = done & i_read & sel_buf;

	// control fields
	wire on         = control_q[iscdr_pkg::CTL_INTERFACE_ON];
	wire irq_allow  = control_q[iscdr_pkg::CTL_IRQ_ALLOW];
	wire bc_allow   = control_q[iscdr_pkg::CTL_BROADCAST_ALOW];
	wire wr_on      = i_writedata[iscdr_pkg::CTL_INTERFACE_ON];
	wire start_wr   = wr_ctl & wr_on
		& i_writedata[iscdr_pkg::CTL_START_REQUEST];

	// event qualification
	wire arb_evt    = i_arb_lost & ~i_rx_ack_slot;            // [R11]
	wire stop_evt   = i_stop_after_ack & ~role_q;             // [R9]
	wire broadcast_hit_flag_evt   = i_gcall_addr & bc_allow & ~role_q;      // [R14]
	wire flags_any  = start_sent_q | byte_done_q | af_q | stop_seen_flag_q
		| contention_lost_flag_q | framing_fault_flag_q | broadcast_hit_flag_q;
	wire common_evt = flags_any;                              // [R19]

	// status images
	wire [7:0] s1_img = {common_evt, 3'h0, byte_done_q, 1'b0,
		role_q, start_sent_q};
	wire [7:0] s2_img = {3'h0, af_q, stop_seen_flag_q, contention_lost_flag_q, framing_fault_flag_q,
		broadcast_hit_flag_q};                                          // [R5]
	wire [7:0] ctl_img = {4'h0, start_pend_q, control_q[2:0]};
	wire [7:0] rd_byte =
		sel_ctl ? ctl_img :
		sel_s1  ? s1_img :
		sel_s2  ? s2_img :
		sel_spd ? speed_q :
		sel_buf ? buffer_q : 8'h00;
	wire mapped = sel_ctl | sel_s1 | sel_s2 | sel_spd | sel_buf;

	// outputs
	assign o_waitrequest = req & ~ack_q;
	assign o_readdata    = rdata_q;
	assign o_rx_ready    = rx_ready_q;
	assign o_start_req   = start_pend_q;
	assign o_tx_load     = tx_load_q;
	assign o_tx_byte     = buffer_q;
	// only start-sent and byte-done stretch; error flags never do
	assign o_scl_hold    = start_sent_q | byte_done_q;        // [R7]
	assign o_role_master = role_q;
	assign o_fast_speed  = speed_q[iscdr_pkg::SPD_FAST_SELECT]; // [R15]
	assign o_scl_divider = speed_q[iscdr_pkg::SPD_DIV_MSB:0];   // [R16]
	assign o_irq         = irq_allow & flags_any;              // [R21]

	// bus handshake and registered read data
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			ack_q   <= 1'b0;
			rdata_q <= iscdr_pkg::RD_UNMAPPED;
		end
		else
		begin
			ack_q   <= req & ~ack_q;
			rdata_q <= mapped ? {24'h0, rd_byte}
				: iscdr_pkg::RD_UNMAPPED;
		end
	end

	// control register; start request bit self-clears into the pending flag
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
			control_q <= iscdr_pkg::RST_CONTROL;
		else if (wr_ctl)
			control_q <= {5'h0, i_writedata[2:0]};
	end

	// speed config survives interface disable, only software alters it
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
			speed_q <= iscdr_pkg::RST_SPEED_CFG;
		else if (wr_spd)
			speed_q <= i_writedata[7:0];              // [R15] [R16]
	end

	// start pending toward the engine, dropped once start is made;
	// a write that turns the interface on may carry the start as well
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || (!on && !start_wr))
			start_pend_q <= 1'b0;
		else if (start_wr)
			start_pend_q <= 1'b1;
		else if (i_start_done)
			start_pend_q <= 1'b0;
	end

	// controller role: start request wins over a same-cycle stop
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || (!on && !start_wr))
			role_q <= 1'b0;                                // [R1]
		else if (start_wr)
			role_q <= 1'b1;                                // [R1]
		else if (i_stop_detected || arb_evt)
			role_q <= 1'b0;                                // [R2]
	end

	// status one read arms the clear of start-sent and byte-done
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || !on)
			s1_read_q <= 1'b0;
		else if (rd_s1)
			s1_read_q <= 1'b1;
		else if (wr_buf || rd_buf)
			s1_read_q <= 1'b0;
	end

	// start-sent: set wins over the read-then-write clear
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || !on)
			start_sent_q <= 1'b0;                          // [R4]
		else if (i_start_done)
			start_sent_q <= 1'b1;                          // [R3]
		else if (s1_read_q && wr_buf)
			start_sent_q <= 1'b0;                          // [R4]
	end

	// byte-done: cleared by status one read then buffer access
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || !on)
			byte_done_q <= 1'b0;
		else if (i_byte_done)
			byte_done_q <= 1'b1;
		else if (s1_read_q && (wr_buf || rd_buf))
			byte_done_q <= 1'b0;
	end

	// nack stays high through the ninth pulse, so an early read re-sets
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || !on)
			af_q <= 1'b0;
		else if (i_nack)
			af_q <= 1'b1;                              // [R6] [R20]
		else if (rd_s2)
			af_q <= 1'b0;                                  // [R6]
	end

	// stop seen in slave role
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || !on)
			stop_seen_flag_q <= 1'b0;
		else if (stop_evt)
			stop_seen_flag_q <= 1'b1;                               // [R9]
		else if (rd_s2)
			stop_seen_flag_q <= 1'b0;                               // [R9]
	end

	// contention lost, masked during the master-receiver ack slot
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || !on)
			contention_lost_flag_q <= 1'b0;
		else if (arb_evt)
			contention_lost_flag_q <= 1'b1;                           // [R10] [R11]
		else if (rd_s2)
			contention_lost_flag_q <= 1'b0;                               // [R10]
	end

	// framing fault on misplaced start or stop
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || !on)
			framing_fault_flag_q <= 1'b0;
		else if (i_misplaced)
			framing_fault_flag_q <= 1'b1;                               // [R12]
		else if (rd_s2)
			framing_fault_flag_q <= 1'b0;                               // [R12]
	end

	// broadcast hit ignores status reads; only a stop or interface disable clears it
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || !on)
			broadcast_hit_flag_q <= 1'b0;
		else if (broadcast_hit_flag_evt)
			broadcast_hit_flag_q <= 1'b1;                               // [R14]
		else if (i_stop_detected)
			broadcast_hit_flag_q <= 1'b0;                               // [R14]
	end

	// byte buffer: software write beats a same-cycle capture
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
			buffer_q <= iscdr_pkg::RST_BYTE_BUFFER;
		else if (wr_buf)
			buffer_q <= i_writedata[7:0];
		else if (i_rx_valid && rx_ready_q)
			buffer_q <= i_rx_byte;                        // [R18]
	end

	// write in transmitter mode launches the byte one cycle later
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
			tx_load_q <= 1'b0;
		else
			tx_load_q <= wr_buf & i_tx_mode & on;         // [R17]
	end

	// receive permission: first byte free, later ones wait for a read
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || !on)
			rx_ready_q <= 1'b0;
		else if (i_rx_valid && rx_ready_q)
			rx_ready_q <= 1'b0;                           // [R18]
		else if (i_addr_done && !i_tx_mode)
			rx_ready_q <= 1'b1;                           // [R18]
		else if (rd_buf && !i_tx_mode)
			rx_ready_q <= 1'b1;                           // [R18]
	end

	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	a_role_on_start: assert property ( // [R1]
		start_wr |=> role_q)
		else $error("role not master after start request");

	a_role_stop_clear: assert property ( // [R2]
		on && !start_wr && (i_stop_detected || arb_evt) |=> !role_q)
		else $error("role kept after stop or lost arbitration");

	a_start_sent_set: assert property ( // [R3]
		on && i_start_done |=> start_sent_q ##0 o_scl_hold)
		else $error("start-sent not set after start");

	a_start_sent_keep: assert property ( // [R4]
		start_sent_q && on && !(s1_read_q && wr_buf) |=> start_sent_q)
		else $error("start-sent cleared without read then write");

	a_status_two_zero: assert property ( // [R5]
		i_read && sel_s2 && !o_waitrequest |-> o_readdata[31:5] == 27'h0)
		else $error("status two upper bits not zero");

	a_af_clear_read: assert property ( // [R6]
		on && rd_s2 && !i_nack |=> !af_q)
		else $error("missing-handshake flag not cleared by read");

	a_af_no_stretch: assert property ( // [R7]
		af_q && !start_sent_q && !byte_done_q |-> !o_scl_hold)
		else $error("SCL stretched by missing-handshake flag");

	a_ack_slot_no_arb: assert property ( // [R11]
		!contention_lost_flag_q && i_arb_lost && i_rx_ack_slot |=> !contention_lost_flag_q)
		else $error("arbitration lost during ack slot");

	a_broadcast_hit_flag_hold: assert property ( // [R14]
		broadcast_hit_flag_q && on && !i_stop_detected |=> broadcast_hit_flag_q)
		else $error("broadcast hit cleared without stop");

	a_speed_kept: assert property ( // [R15]
		!wr_spd |=> $stable(o_fast_speed) && $stable(o_scl_divider))
		else $error("speed config changed without write");

	a_tx_launch: assert property ( // [R17]
		wr_buf && i_tx_mode && on |=> o_tx_load && o_tx_byte ==
		$past(i_writedata[7:0]))
		else $error("byte buffer write did not launch transmit");

	a_irq_gate: assert property ( // [R21]
		!irq_allow |-> !o_irq)
		else $error("interrupt without irq allow");

	a_bus_answer: assert property (
		req |-> ##[0:1] !o_waitrequest)
		else $error("bus access not answered in time");

	c_master_start: cover property (start_wr ##[1:20] start_sent_q);
	c_nack_reread: cover property (rd_s2 && i_nack ##1 af_q);
	c_rx_second: cover property (rd_buf ##[1:30] (i_rx_valid && o_rx_ready));
	c_gcall_stop: cover property (broadcast_hit_flag_q ##1 i_stop_detected);

endmodule // iscdr_core

// [sim/iscdr_bus_model.sv]
// far-side model: the bus engine that answers start, transmit and receive
`timescale 1ns/10ps
module iscdr_bus_model (
	input  wire logic       i_clk,        // clock
	input  wire logic       i_resetn,     // synchronous reset, low
	input  wire logic       i_start_req,  // start pending
	input  wire logic       i_tx_load,    // byte handed over to send
	input  wire logic       i_rx_ready,   // block may take a byte
	input  wire logic       i_slow,       // answer the start late
	input  wire logic [7:0] i_next_byte,  // byte to deliver
	output logic            o_start_done, // start made, pulse
	output logic            o_byte_done,  // byte sent, pulse
	output logic            o_rx_valid,   // byte offered
	output logic      [7:0] o_rx_byte     // offered byte
);
	logic [2:0] cnt_q;
	logic       busy_q;

	// one answer per request; busy blocks a second pulse while it drops
	always_ff @(posedge i_clk)
	begin
		o_start_done <= 1'b0;
		if (!i_resetn || !i_start_req)
			busy_q <= 1'b0;
		else if (!busy_q)
		begin
			busy_q <= 1'b1;
			cnt_q  <= i_slow ? 3'h5 : 3'h1;
		end
		else if (cnt_q != 3'h0)
		begin
			cnt_q        <= cnt_q - 3'h1;
			o_start_done <= (cnt_q == 3'h1);
		end
		o_byte_done <= i_resetn & i_tx_load;
	end

	// an idle data path shows the inverse, never a stale copy of the byte
	assign o_rx_valid = i_rx_ready;
	assign o_rx_byte  = i_rx_ready ? i_next_byte : ~i_next_byte;
endmodule // iscdr_bus_model

// [sim/i2c_status_clock_data_regs_tb_top.sv]
// self-checking bench for the status, clock and data register block
`timescale 1ns/10ps
module i2c_status_clock_data_regs_tb_top;
	localparam logic [4:0] CT = iscdr_pkg::OFS_CONTROL;
	localparam logic [4:0] S1 = iscdr_pkg::OFS_STATUS_ONE;
	localparam logic [4:0] S2 = iscdr_pkg::OFS_STATUS_TWO;
	localparam logic [4:0] SP = iscdr_pkg::OFS_SPEED_CFG;
	localparam logic [4:0] BB = iscdr_pkg::OFS_BYTE_BUFFER;
	logic        i_clk, i_resetn, i_read, i_write, i_start_done, i_nack;
	logic        i_stop_detected, i_stop_after_ack, i_arb_lost, i_misplaced;
	logic        i_rx_ack_slot, i_gcall_addr, i_byte_done, i_tx_mode;
	logic        i_addr_done, i_rx_valid, i_slow, o_rx_ready, o_start_req;
	logic        o_tx_load, o_scl_hold, o_role_master, o_fast_speed, o_irq;
	logic        o_waitrequest, wait_s;
	logic [4:0]  i_address;
	logic [3:0]  i_byteenable;
	logic [31:0] i_writedata, o_readdata, rd_s;
	logic [7:0]  i_rx_byte, o_tx_byte, next_byte, tx_seen, q, v, b, sv;
	logic [6:0]  o_scl_divider;
	int          miscompares, num_checks, tx_cnt, seed, k;
	logic [6:0]  ev;
	// engine event inputs, one bit each, picked by these codes
	localparam int EV_ARB  = 0;
	localparam int EV_NACK = 1;
	localparam int EV_MIS  = 2;
	localparam int EV_SAA  = 3;
	localparam int EV_GC   = 4;
	localparam int EV_STOP = 5;
	localparam int EV_ADDR = 6;
	assign {i_addr_done, i_stop_detected, i_gcall_addr, i_stop_after_ack,
		i_misplaced, i_nack, i_arb_lost} = ev;

	iscdr_core i_dut (
		.i_clk            (i_clk),
		.i_resetn         (i_resetn),
		.i_address        (i_address),
		.i_read           (i_read),
		.i_write          (i_write),
		.i_byteenable     (i_byteenable),
		.i_writedata      (i_writedata),
		.o_readdata       (o_readdata),
		.o_waitrequest    (o_waitrequest),
		.i_start_done     (i_start_done),
		.i_stop_detected  (i_stop_detected),
		.i_stop_after_ack (i_stop_after_ack),
		.i_arb_lost       (i_arb_lost),
		.i_rx_ack_slot    (i_rx_ack_slot),
		.i_nack           (i_nack),
		.i_misplaced      (i_misplaced),
		.i_gcall_addr     (i_gcall_addr),
		.i_byte_done      (i_byte_done),
		.i_tx_mode        (i_tx_mode),
		.i_addr_done      (i_addr_done),
		.i_rx_valid       (i_rx_valid),
		.i_rx_byte        (i_rx_byte),
		.o_rx_ready       (o_rx_ready),
		.o_start_req      (o_start_req),
		.o_tx_load        (o_tx_load),
		.o_tx_byte        (o_tx_byte),
		.o_scl_hold       (o_scl_hold),
		.o_role_master    (o_role_master),
		.o_fast_speed     (o_fast_speed),
		.o_scl_divider    (o_scl_divider),
		.o_irq            (o_irq)
	);
	iscdr_bus_model i_bus (.i_clk(i_clk), .i_resetn(i_resetn),
		.i_start_req(o_start_req), .i_tx_load(o_tx_load),
		.i_rx_ready(o_rx_ready), .i_slow(i_slow), .i_next_byte(next_byte),
		.o_start_done(i_start_done), .o_byte_done(i_byte_done),
		.o_rx_valid(i_rx_valid), .o_rx_byte(i_rx_byte));

	initial
	begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	// sample mid-cycle so edge updates have landed before we look
	always @(negedge i_clk)
	begin
		wait_s = o_waitrequest;
		rd_s   = o_readdata;
		if (o_tx_load === 1'b1)
		begin
			tx_cnt++;
			tx_seen = o_tx_byte;
		end
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one avalon access; entered just after a rising edge, leaves on one
	task automatic acc(input logic wr, input logic [4:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		i_address   <= a;
		i_write     <= wr;
		i_read      <= ~wr;
		i_writedata <= {24'h0, d};
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (wait_s !== 1'b0 && n < 20);
		if (n >= 20)
		begin
			miscompares++;
			finish_test();
		end
		q = rd_s[7:0];
		i_read  <= 1'b0;
		i_write <= 1'b0;
		@(posedge i_clk);
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
		acc(1'b0, a, 8'h00);
		chk(q, exp);
	endtask

	// one-cycle engine event, then one quiet cycle
	task automatic pulse(input int e);
		ev[e] <= 1'b1;
		@(posedge i_clk);
		ev[e] <= 1'b0;
		@(posedge i_clk);
	endtask

	// status two bit expected for each engine event of the flag loop
	function automatic logic [7:0] ev_bit(input int e);
		case (e)
			0: return 8'h01 << iscdr_pkg::S2_MISSING_HSHAKE;
			1: return 8'h01 << iscdr_pkg::S2_FRAMING_FAULT;
			default: return 8'h01 << iscdr_pkg::S2_STOP_SEEN;
		endcase
	endfunction

	initial
	begin
		seed = 32'hc385;
		{i_read, i_write, i_rx_ack_slot, i_tx_mode, i_slow} = 5'h00;
		i_resetn     = 1'b0;
		ev           = 7'h00;
		i_address    = 5'h00;
		i_writedata  = 32'h0;
		i_byteenable = 4'hF;
		next_byte    = 8'h00;
		miscompares  = 0;
		num_checks   = 0;
		repeat (16) @(posedge i_clk);
		i_resetn <= 1'b1;
		@(posedge i_clk);
		// every mapped register and one unmapped word read zero
		for (k = 0; k < 6; k++)
			rd_chk(5'(4 * k), 8'h00);
		$display("test 1 done");
		// random speed settings read back and reach the clock outputs
		repeat (4)
		begin
			v = 8'($random(seed));
			acc(1'b1, SP, v);
			rd_chk(SP, v);
			chk({o_fast_speed, o_scl_divider}, v);
		end
		sv = v;
		i_byteenable <= 4'h0;
		acc(1'b1, SP, ~v);
		i_byteenable <= 4'hF;
		rd_chk(SP, v);
		$display("test 2 done");
		// start with a late engine, then the address byte goes out
		i_slow <= 1'b1;
		acc(1'b1, CT, 8'h03);
		acc(1'b1, CT, 8'h0B);
		chk(o_role_master, 1'b1);
		chk(o_start_req, 1'b1);
		k = 0;
		do
		begin
			acc(1'b0, S1, 8'h00);
			k++;
		end
		while (q[0] !== 1'b1 && k < 20);
		// an engine that never answers ends the run here
		if (k >= 20)
		begin
			miscompares++;
			finish_test();
		end
		chk(q[1:0], 2'b11);
		chk(o_start_req, 1'b0);
		chk(o_irq, 1'b1);
		chk(o_scl_hold, 1'b1);
		b = 8'($random(seed));
		i_tx_mode <= 1'b1;
		acc(1'b1, BB, b);
		repeat (2) @(posedge i_clk);
		chk(tx_cnt, 1);
		chk(tx_seen, b);
		rd_chk(S1, 8'h8A);
		acc(1'b0, BB, 8'h00);
		rd_chk(S1, 8'h02);
		$display("test 3 done");
		// arbitration loss ignored in the ack slot, taken outside it
		i_rx_ack_slot <= 1'b1;
		pulse(EV_ARB);
		i_rx_ack_slot <= 1'b0;
		rd_chk(S2, 8'h00);
		chk(o_role_master, 1'b1);
		pulse(EV_ARB);
		chk(o_role_master, 1'b0);
		rd_chk(S2, 8'h04);
		rd_chk(S2, 8'h00);
		$display("test 4 done");
		// each error event sets its own flag, no stretch, read clears;
		// codes 1 to 3 are nack, misplaced condition, stop after ack
		for (k = 0; k < 3; k++)
		begin
			pulse(k + 1);
			// the master answers a bus error with a stop
			if (k == 1)
				pulse(EV_STOP);
			chk(o_scl_hold, 1'b0);
			chk(o_irq, 1'b1);
			rd_chk(S1, 8'h80);
			rd_chk(S2, ev_bit(k));
			rd_chk(S2, 8'h00);
		end
		// nack still present during the read: the flag comes back
		ev[EV_NACK] <= 1'b1;
		acc(1'b0, S2, 8'h00);
		// software lets both lines go once the nack is handled
		ev[EV_NACK] <= 1'b0;
		rd_chk(S2, 8'h10);
		rd_chk(S2, 8'h00);
		$display("test 5 done");
		// general call: needs the allow bit, survives reads, stop clears
		pulse(EV_GC);
		rd_chk(S2, 8'h00);
		acc(1'b1, CT, 8'h07);
		pulse(EV_GC);
		rd_chk(S2, 8'h01);
		rd_chk(S2, 8'h01);
		pulse(EV_STOP);
		rd_chk(S2, 8'h00);
		$display("test 6 done");
		// receive: first byte taken at once, next only after a read
		i_tx_mode <= 1'b0;
		b = 8'($random(seed));
		next_byte <= b;
		pulse(EV_ADDR);
		repeat (3) @(posedge i_clk);
		chk(o_rx_ready, 1'b0);
		v = b ^ (8'h01 | 8'($random(seed)));
		next_byte <= v;
		repeat (3) @(posedge i_clk);
		rd_chk(BB, b);
		repeat (3) @(posedge i_clk);
		rd_chk(BB, v);
		$display("test 7 done");
		// disable in mid-run: flags and role drop, speed stays
		i_slow <= 1'b0;
		acc(1'b1, CT, 8'h0B);
		pulse(EV_MIS);
		acc(1'b1, CT, 8'h00);
		// the clear lands one edge after the write completes
		@(posedge i_clk);
		chk(o_role_master, 1'b0);
		chk(o_irq, 1'b0);
		rd_chk(S2, 8'h00);
		rd_chk(S1, 8'h00);
		rd_chk(SP, sv);
		$display("test 8 done");
		finish_test();
	end
endmodule // i2c_status_clock_data_regs_tb_top
